// file: src/rcs_pkg.sv
// Package with register map, field layout, reset values and timing for the reset cause block.
package rcs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned RCS_ADDR_W = 8;                       // Register address width.
  localparam logic [7:0] RCS_OFF_CAUSE = 8'h00;                 // Reset cause status, read only.
  localparam logic [7:0] RCS_OFF_CTRL = 8'h04;                  // Source and mode control.
  localparam logic [7:0] RCS_OFF_WAKE_EN = 8'h08;               // Wakeup source enables.
  localparam logic [7:0] RCS_OFF_IRQ_STAT = 8'h0c;              // Sticky event flags, write one to clear.
  localparam logic [7:0] RCS_OFF_IRQ_MASK = 8'h10;              // Event mask, one lets the event through.

  // ----------------------------------------------------------------
  // Cause register fields
  // ----------------------------------------------------------------
  localparam int unsigned RCS_BIT_POR = 7;                      // Power-on detection.
  localparam int unsigned RCS_BIT_PIN = 6;                      // External reset pin.
  localparam int unsigned RCS_BIT_WATCHDOG = 5;                 // Watchdog timeout.
  localparam int unsigned RCS_BIT_RSVD = 4;                     // Reserved, always zero.
  localparam int unsigned RCS_BIT_LOCK_LOSS = 3;                // Loss of lock.
  localparam int unsigned RCS_BIT_CLK_LOSS = 2;                 // Loss of clock.
  localparam int unsigned RCS_BIT_LOW_VOLT = 1;                 // Low voltage.
  localparam int unsigned RCS_BIT_WAKE = 0;                     // Low-leakage wakeup.

  // Cause values for the documented reset types.
  localparam logic [7:0] RCS_CAUSE_POR = 8'h82;                 // Power-on, low voltage included.
  localparam logic [7:0] RCS_CAUSE_LOW_VOLT = 8'h02;            // Low voltage without power-on.
  localparam logic [7:0] RCS_CAUSE_PIN_WAKE = 8'h41;            // Pin wakeup from deep stop.
  localparam logic [7:0] RCS_CAUSE_WAKE = 8'h01;                // Other wakeup from deep stop.

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned RCS_CTRL_LV_RST_EN = 0;               // Low-voltage reset enable.
  localparam int unsigned RCS_CTRL_CME = 1;                     // Clock monitor enable.
  localparam int unsigned RCS_CTRL_WTS_LSB = 2;                 // Watchdog timeout select, 2 bits.
  localparam int unsigned RCS_CTRL_MODE_LSB = 4;                // Power mode, 2 bits.
  localparam logic [1:0] RCS_WTS_OFF = 2'h0;                    // Watchdog disabled.
  localparam logic [5:0] RCS_CTRL_RESET = 6'h0c;                // Watchdog on, run mode.

  // Interrupt flag positions.
  localparam int unsigned RCS_IRQ_CAUGHT = 0;                   // A reset cause was captured.
  localparam int unsigned RCS_IRQ_SHALLOW_WAKE = 1;             // Non-reset wakeup in shallow stop.
  localparam int unsigned RCS_IRQ_W = 2;                        // Number of interrupt flags.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned RCS_CLK_PERIOD_PS = 8000;             // Core clock period.
  localparam int unsigned RCS_RESET_HOLD_NS = 1000;             // Least chip reset pulse.
  localparam int unsigned RCS_RESET_HOLD_CYC =
    (RCS_RESET_HOLD_NS * 1000 + RCS_CLK_PERIOD_PS - 1) / RCS_CLK_PERIOD_PS;

  // Power modes.
  typedef enum logic [1:0] {
    RCS_MODE_RUN = 2'h0,
    RCS_MODE_SHALLOW = 2'h1,
    RCS_MODE_DEEP = 2'h2
  } rcs_mode_t;

  // Sequencer states, Gray coded.
  typedef enum logic [1:0] {
    RCS_ST_IDLE = 2'h0,
    RCS_ST_HOLD = 2'h1
  } rcs_state_t;

  // Reset source levels, all active high after synchronisation.
  typedef struct packed {
    logic low_volt;
    logic pin;
    logic watchdog;
    logic lock_lost;
    logic clk_lost;
  } rcs_src_t;

  // Software configuration bundle.
  typedef struct packed {
    rcs_mode_t mode;
    logic [1:0] wts;
    logic cme;
    logic low_voltage_reset_enable;
  } rcs_cfg_t;

endpackage

// file: src/rcs_reset_cause.sv
// Reset cause capture, reset pulse sequencer and register slave.
//
// Function
// R1 - Power-on reset reads 0x82.
// R2 - Low-voltage reset without power-on reads 0x02.
// R3 - Deep-stop pin wakeup reads 0x41.
// R4 - Deep-stop other wakeup reads 0x01.
// R5 - Other resets set only their flag.
// R6 - Bit 7 power-on, with low-voltage flag.
// R7 - Bit 6 external reset pin low.
// R8 - Bit 5 watchdog timeout.
// R9 - Watchdog select 00 blocks watchdog reset.
// R10 - Bit 4 reserved, reads zero.
// R11 - Bit 3 PLL loss of lock.
// R12 - Bit 2 clock loss, monitor enabled only.
// R13 - Bit 1 low voltage, enable required; power-on.
// R14 - Bit 0 enabled low-leakage wakeup source.
// R15 - Shallow stop: only pin wakes by reset.
// R16 - Deep stop: every enabled wakeup resets.
// R17 - Wakeup flag cleared by other resets.
// R18 - Cause flags read only, writes ignored.
// R19 - Latch flags, hold until next reset.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

module rcs_reset_cause
  import rcs_pkg::*;
#(
  parameter int unsigned WAKE_W = 8,
  parameter int unsigned HOLD_CYC = RCS_RESET_HOLD_CYC
)
(
  // Clock and power-on reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Reset sources from other domains.
  input wire logic low_volt_trip,
  input wire logic reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic lock_loss,
  input wire logic clock_loss,
  input wire logic [WAKE_W-1:0] wake_src,
  // Register port.
  input wire logic [RCS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rd_data,
  // Results.
  output logic chip_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WAKE_W < 1 || WAKE_W > 32)
  begin : g_bad_wake
    $error("WAKE_W must lie between 1 and 32");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 65535)
  begin : g_bad_hold
    $error("HOLD_CYC must lie between 1 and 65535");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Works out the cause byte for a set of live sources; zero means no reset.
  function automatic logic [7:0] cause_of(input rcs_src_t s, input rcs_cfg_t c,
                                          input logic wake_any);
    logic [7:0] v;
    v = 8'h00;
    if (s.low_volt && c.low_voltage_reset_enable)
    begin
      v = RCS_CAUSE_LOW_VOLT; // R13 R2
    end
    else if (s.pin)
    begin
      // A pin reset out of either stop mode is also a wakeup reset.
      if (c.mode == RCS_MODE_SHALLOW || c.mode == RCS_MODE_DEEP)
      begin
        v = RCS_CAUSE_PIN_WAKE; // R3 R15 R14
      end
      else
      begin
        v[RCS_BIT_PIN] = 1'b1; // R7 R5
      end
    end
    else if (wake_any && c.mode == RCS_MODE_DEEP)
    begin
      v = RCS_CAUSE_WAKE; // R4 R16 R14
    end
    else if (s.watchdog && c.wts != RCS_WTS_OFF)
    begin
      v[RCS_BIT_WATCHDOG] = 1'b1; // R8 R9 R5
    end
    else if (s.lock_lost)
    begin
      v[RCS_BIT_LOCK_LOSS] = 1'b1; // R11 R5
    end
    else if (s.clk_lost && c.cme)
    begin
      v[RCS_BIT_CLK_LOSS] = 1'b1; // R12 R5
    end
    v[RCS_BIT_RSVD] = 1'b0; // R10
    return v;
  endfunction

  // Returns true when the byte address matches a register offset.
  function automatic logic hit(input logic [RCS_ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  rcs_src_t src_raw; // Raw source levels, active high.
  rcs_src_t src_m_q; // First synchroniser stage.
  rcs_src_t src_q; // Second stage, safe to read.
  logic [WAKE_W-1:0] wake_m_q; // First wakeup stage.
  logic [WAKE_W-1:0] wake_q; // Second wakeup stage.

  // Gathers the pins into one bundle; the reset pin is active low.
  always_comb
  begin
    src_raw.low_volt = low_volt_trip;
    src_raw.pin = ~reset_pin_n; // R7
    src_raw.watchdog = watchdog_timeout;
    src_raw.lock_lost = lock_loss;
    src_raw.clk_lost = clock_loss;
  end

  // Two flip-flops per source; only the second stage feeds logic.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      src_m_q <= '0;
      src_q <= '0;
      wake_m_q <= '0;
      wake_q <= '0;
    end
    else
    begin
      src_m_q <= src_raw;
      src_q <= src_m_q;
      wake_m_q <= wake_src;
      wake_q <= wake_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  rcs_cfg_t cfg_q; // Source enables, watchdog select, mode.
  rcs_cfg_t cfg_d;
  logic [WAKE_W-1:0] wake_en_q; // Wakeup source enables.
  logic [WAKE_W-1:0] wake_en_d;
  logic [RCS_IRQ_W-1:0] irq_mask_q; // Interrupt mask.
  logic [RCS_IRQ_W-1:0] irq_mask_d;
  logic wr_ctrl; // Write to control.
  logic wr_wake; // Write to wake enables.
  logic wr_mask; // Write to mask.
  logic wr_stat; // Write to interrupt status.
  logic reset_start; // A chip reset begins this cycle.

  // Decodes the write strobes.
  always_comb
  begin
    wr_ctrl = reg_wr_en && hit(reg_addr, RCS_OFF_CTRL);
    wr_wake = reg_wr_en && hit(reg_addr, RCS_OFF_WAKE_EN);
    wr_mask = reg_wr_en && hit(reg_addr, RCS_OFF_IRQ_MASK);
    wr_stat = reg_wr_en && hit(reg_addr, RCS_OFF_IRQ_STAT);
  end

  // Next values of the control registers; a chip reset sends mode back to run.
  always_comb
  begin
    cfg_d = cfg_q;
    wake_en_d = wake_en_q;
    irq_mask_d = irq_mask_q;
    if (wr_ctrl)
    begin
      cfg_d.low_voltage_reset_enable = reg_wr_data[RCS_CTRL_LV_RST_EN];
      cfg_d.cme = reg_wr_data[RCS_CTRL_CME];
      cfg_d.wts = reg_wr_data[RCS_CTRL_WTS_LSB +: 2];
      cfg_d.mode = rcs_mode_t'(reg_wr_data[RCS_CTRL_MODE_LSB +: 2]);
    end
    if (reset_start)
    begin
      cfg_d.mode = RCS_MODE_RUN;
    end
    if (wr_wake)
    begin
      wake_en_d = reg_wr_data[WAKE_W-1:0];
    end
    if (wr_mask)
    begin
      irq_mask_d = reg_wr_data[RCS_IRQ_W-1:0];
    end
  end

  // Registers the control state.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cfg_q <= rcs_cfg_t'(RCS_CTRL_RESET);
      wake_en_q <= '0;
      irq_mask_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      wake_en_q <= wake_en_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer and cause capture
  // ----------------------------------------------------------------
  rcs_state_t state_q; // Sequencer state.
  rcs_state_t state_d;
  logic [15:0] hold_q; // Cycles left in the reset pulse.
  logic [15:0] hold_d;
  logic [7:0] cause_q; // Latched cause flags.
  logic [7:0] cause_d;
  logic chip_reset_q; // Reset pulse to the chip.
  logic chip_reset_d;
  logic wake_any; // Any enabled wakeup source is active.
  logic [7:0] cause_now; // Cause that the live sources would give.
  logic shallow_wake; // Wakeup in shallow stop that must not reset.

  // Finds the cause of a new reset; in shallow stop only the pin wakes by reset.
  always_comb
  begin
    wake_any = |(wake_q & wake_en_q);
    cause_now = cause_of(src_q, cfg_q, wake_any);
    shallow_wake = wake_any && cfg_q.mode == RCS_MODE_SHALLOW && state_q == RCS_ST_IDLE; // R15
    reset_start = state_q == RCS_ST_IDLE && cause_now != 8'h00;
  end

  // Next state: catch the cause, then hold the reset pulse for its length.
  always_comb
  begin
    state_d = state_q;
    hold_d = hold_q;
    cause_d = cause_q; // R19
    chip_reset_d = chip_reset_q;
    case (state_q)
      RCS_ST_IDLE:
      begin
        if (reset_start)
        begin
          // The whole byte is replaced, which clears a stale wakeup flag.
          cause_d = cause_now; // R5 R17 R19
          hold_d = 16'(HOLD_CYC - 1);
          chip_reset_d = 1'b1;
          state_d = RCS_ST_HOLD;
        end
      end
      RCS_ST_HOLD:
      begin
        // Sources are ignored here, so the latched cause stays stable.
        if (hold_q == 16'h0000)
        begin
          chip_reset_d = 1'b0;
          state_d = RCS_ST_IDLE;
        end
        else
        begin
          hold_d = hold_q - 16'h0001;
        end
      end
      default:
      begin
        chip_reset_d = 1'b0;
        state_d = RCS_ST_IDLE;
      end
    endcase
  end

  // Registers the sequencer; power-on leaves the power-on cause.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q <= RCS_ST_IDLE;
      hold_q <= '0;
      cause_q <= RCS_CAUSE_POR; // R1 R6 R13
      chip_reset_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hold_q <= hold_d;
      cause_q <= cause_d;
      chip_reset_q <= chip_reset_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic [RCS_IRQ_W-1:0] irq_stat_q; // Sticky event flags.
  logic [RCS_IRQ_W-1:0] irq_stat_d;
  logic [RCS_IRQ_W-1:0] irq_set; // Events this cycle.
  logic irq_q; // Registered interrupt line.
  logic irq_d;

  // Sets win over a same-cycle write-one clear.
  always_comb
  begin
    irq_set = '0;
    irq_set[RCS_IRQ_CAUGHT] = reset_start;
    irq_set[RCS_IRQ_SHALLOW_WAKE] = shallow_wake;
    irq_stat_d = irq_stat_q;
    if (wr_stat)
    begin
      irq_stat_d = irq_stat_q & ~reg_wr_data[RCS_IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_set;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // Registers the flags and the interrupt output.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_data_q; // Read data, valid the cycle after the strobe.
  logic [31:0] rd_data_d;

  // Selects read data; unmapped addresses and idle cycles give zero.
  always_comb
  begin
    rd_data_d = 32'h00000000;
    if (reg_rd_en)
    begin
      if (hit(reg_addr, RCS_OFF_CAUSE))
      begin
        rd_data_d[7:0] = cause_q; // R18 R10
      end
      else if (hit(reg_addr, RCS_OFF_CTRL))
      begin
        rd_data_d[5:0] = cfg_q;
      end
      else if (hit(reg_addr, RCS_OFF_WAKE_EN))
      begin
        rd_data_d[WAKE_W-1:0] = wake_en_q;
      end
      else if (hit(reg_addr, RCS_OFF_IRQ_STAT))
      begin
        rd_data_d[RCS_IRQ_W-1:0] = irq_stat_q;
      end
      else if (hit(reg_addr, RCS_OFF_IRQ_MASK))
      begin
        rd_data_d[RCS_IRQ_W-1:0] = irq_mask_q;
      end
      else
      begin
        rd_data_d = 32'h00000000;
      end
    end
  end

  // Registers the read data.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rd_data = rd_data_q;
  assign chip_reset = chip_reset_q;
  assign irq = irq_q;

endmodule

// file: tb/rcs_reset_cause_asserts.sv
// Assertions on the ports of the reset cause block.
`timescale 1ns/100ps

module rcs_reset_cause_asserts
  import rcs_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Watched ports.
  input wire logic reset_pin_n,
  input wire logic lock_loss,
  input wire logic [RCS_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_rd_data,
  input wire logic chip_reset
);
  // ----
  // Helper state
  // ----
  logic rd_q; // Cause read data stands now.
  logic rd_d;
  logic fresh_q; // No chip reset since power-on.
  logic fresh_d;
  logic have_q; // A cause value was read since the last reset.
  logic have_d;
  logic [7:0] last_q; // Last cause value read.
  logic [7:0] last_d;

  // Track cause reads; a reset pulse makes the last value stale.
  always_comb
  begin
    rd_d = reg_rd_en && reg_addr == RCS_OFF_CAUSE;
    fresh_d = fresh_q && !chip_reset;
    have_d = (have_q || rd_q) && !chip_reset;
    last_d = rd_q ? reg_rd_data[7:0] : last_q;
    if (!resetn)
    begin
      rd_d = 1'b0;
      fresh_d = 1'b1;
      have_d = 1'b0;
    end
  end

  // Register the helper state.
  always_ff @(posedge core_clk)
  begin
    rd_q <= rd_d;
    fresh_q <= fresh_d;
    have_q <= have_d;
    last_q <= last_d;
  end

  // ----
  // Assertions
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_por_cause_value: assert property (rd_q && fresh_q |-> reg_rd_data == 32'h82)
    else $error("cause after power-on is not 82");
  a_rsvd_bits_zero: assert property (rd_q |-> !reg_rd_data[4] && !(|reg_rd_data[31:8]))
    else $error("reserved cause bits set");
  a_por_has_lvd: assert property (rd_q && reg_rd_data[7] |-> reg_rd_data[1])
    else $error("power-on flag without low-voltage flag");
  a_wake_flag_pairs: assert property (rd_q && reg_rd_data[0] |-> reg_rd_data[7:0] inside {8'h41, 8'h01})
    else $error("wakeup flag with foreign flags");
  a_single_flag: assert property (rd_q |-> $onehot(reg_rd_data[7:0]) || reg_rd_data[7:0] inside {8'h82, 8'h41})
    else $error("cause holds an illegal flag mix");
  a_cause_held: assert property (rd_q && have_q |-> reg_rd_data[7:0] == last_q)
    else $error("cause changed without a reset");
  a_pin_resets: assert property ($fell(reset_pin_n) && !chip_reset |-> ##[1:4] chip_reset)
    else $error("reset pin gave no chip reset");
  a_lock_loss_resets: assert property ($rose(lock_loss) && !chip_reset |-> ##[1:4] chip_reset)
    else $error("lock loss gave no chip reset");
endmodule

bind rcs_reset_cause rcs_reset_cause_asserts i_rcs_reset_cause_asserts (
  .core_clk(core_clk),
  .resetn(resetn),
  .reset_pin_n(reset_pin_n),
  .lock_loss(lock_loss),
  .reg_addr(reg_addr),
  .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data),
  .chip_reset(chip_reset)
);

// file: tb/rcs_src_model.sv
// Model of the on-chip reset and wakeup sources.
`timescale 1ns/100ps

module rcs_src_model
  import rcs_pkg::*;
#(
  parameter int unsigned WAKE_W = 8
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Bench requests and the block's reset pulse.
  input wire rcs_src_t src_req,
  input wire logic [WAKE_W-1:0] wake_req,
  input wire logic chip_reset,
  // Source levels toward the block.
  output logic low_volt_trip,
  output logic reset_pin_n,
  output logic watchdog_timeout,
  output logic lock_loss,
  output logic clock_loss,
  output logic [WAKE_W-1:0] wake_src
);
  rcs_src_t lvl_q; // Held source levels.
  rcs_src_t lvl_d;
  logic [WAKE_W-1:0] wake_q; // Held wakeup levels.
  logic [WAKE_W-1:0] wake_d;
  logic [3:0] age_q; // Cycles since the last request, saturating.
  logic [3:0] age_d;
  logic clr; // Drop every level.

  // A source stays active until a reset pulse answers it or eight cycles pass,
  // so a refused source does not linger into the next trial.
  always_comb
  begin
    clr = !resetn || chip_reset || age_q == 4'h8;
    lvl_d = (clr ? '0 : lvl_q) | src_req;
    wake_d = (clr ? '0 : wake_q) | wake_req;
    age_d = age_q + {3'h0, age_q != 4'h8};
    if (|src_req || |wake_req)
      age_d = 4'h0;
  end

  // Register the levels.
  always_ff @(posedge core_clk)
  begin
    lvl_q <= lvl_d;
    wake_q <= wake_d;
    age_q <= age_d;
  end

  // The pin is active low and pulled up when released.
  assign low_volt_trip = lvl_q.low_volt;
  assign reset_pin_n = !lvl_q.pin;
  assign watchdog_timeout = lvl_q.watchdog;
  assign lock_loss = lvl_q.lock_lost;
  assign clock_loss = lvl_q.clk_lost;
  assign wake_src = wake_q;
endmodule

// file: tb/rcs_reset_cause_tb.sv
// Self-checking bench for the reset cause block.
`timescale 1ns/100ps

module rcs_reset_cause_tb
  import rcs_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wr_data = 32'h0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [31:0] reg_rd_data;
  logic chip_reset;
  logic irq;
  rcs_src_t src_req = '0; // Source requests to the model.
  logic [7:0] wake_req = 8'h00;
  logic low_volt_trip, reset_pin_n, watchdog_timeout, lock_loss, clock_loss;
  logic [7:0] wake_src;
  logic [15:0] lfsr_q = 16'he271; // Fixed seed.
  int mismatches = 0;
  int cmp_count = 0;

  initial forever #4 core_clk = ~core_clk;

  rcs_reset_cause #(.WAKE_W(8), .HOLD_CYC(4)) i_rcs_reset_cause (
    .core_clk(core_clk), .resetn(resetn), .low_volt_trip(low_volt_trip),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout), .lock_loss(lock_loss),
    .clock_loss(clock_loss), .wake_src(wake_src), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .chip_reset(chip_reset), .irq(irq));

  rcs_src_model #(.WAKE_W(8)) i_rcs_src_model (
    .core_clk(core_clk), .resetn(resetn), .src_req(src_req), .wake_req(wake_req),
    .chip_reset(chip_reset), .low_volt_trip(low_volt_trip), .reset_pin_n(reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .lock_loss(lock_loss), .clock_loss(clock_loss),
    .wake_src(wake_src));

  // Next value of the random sequence.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected cause value, zero when no reset should follow.
  function automatic logic [7:0] exp_cause(input rcs_src_t s, input logic [7:0] w,
                                           input logic [5:0] c, input logic [7:0] en);
    rcs_cfg_t g;
    g = rcs_cfg_t'(c);
    if (s.low_volt && g.low_voltage_reset_enable)
      return RCS_CAUSE_LOW_VOLT;
    if (s.pin)
      return (g.mode != RCS_MODE_RUN) ? RCS_CAUSE_PIN_WAKE : 8'h40;
    if (g.mode == RCS_MODE_DEEP && (w & en) != 8'h00)
      return RCS_CAUSE_WAKE;
    if (s.watchdog && g.wts != RCS_WTS_OFF)
      return 8'h20;
    if (s.lock_lost)
      return 8'h08;
    if (s.clk_lost && g.cme)
      return 8'h04;
    return 8'h00;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  // One-cycle register read; data stand in the next cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check(v, e);
  endtask

  // Configure, raise sources for one request, then judge the outcome.
  task automatic trial(input rcs_src_t s, input logic [7:0] w, input logic [5:0] c,
                       input logic [7:0] en);
    logic [7:0] e;
    logic [31:0] v;
    logic seen;
    e = exp_cause(s, w, c, en);
    seen = 1'b0;
    wr(RCS_OFF_CTRL, {26'h0, c});
    wr(RCS_OFF_WAKE_EN, {24'h0, en});
    wr(RCS_OFF_IRQ_STAT, 32'h3);
    @(posedge core_clk);
    src_req <= s;
    wake_req <= w;
    @(posedge core_clk);
    src_req <= '0;
    wake_req <= 8'h00;
    repeat (20)
    begin
      @(negedge core_clk);
      seen = seen | (chip_reset === 1'b1);
    end
    check(seen, e != 8'h00);
    if (seen)
    begin
      chk_reg(RCS_OFF_CAUSE, {24'h0, e});
      wr(RCS_OFF_CAUSE, {24'h0, ~e});
      chk_reg(RCS_OFF_CAUSE, {24'h0, e});
    end
    rd(RCS_OFF_IRQ_STAT, v);
    check(v[0], seen);
    if (!seen)
      check(v[1], c[5:4] == RCS_MODE_SHALLOW && (w & en) != 8'h00);
  endtask

  // Main sequence: corner cases first, then random trials.
  initial
  begin
    logic [15:0] r;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    chk_reg(RCS_OFF_CAUSE, 32'h82);
    wr(RCS_OFF_CAUSE, 32'hff);
    chk_reg(RCS_OFF_CAUSE, 32'h82);
    chk_reg(8'h14, 32'h0);
    trial(5'h10, 8'h00, 6'h01, 8'h00);
    trial(5'h10, 8'h00, 6'h00, 8'h00);
    trial(5'h08, 8'h00, 6'h20, 8'h00);
    trial(5'h00, 8'h04, 6'h20, 8'h04);
    trial(5'h02, 8'h00, 6'h04, 8'h00);
    trial(5'h00, 8'h04, 6'h20, 8'h00);
    trial(5'h04, 8'h00, 6'h00, 8'h00);
    trial(5'h04, 8'h00, 6'h0c, 8'h00);
    trial(5'h01, 8'h00, 6'h0c, 8'h00);
    trial(5'h01, 8'h00, 6'h0e, 8'h00);
    trial(5'h00, 8'h80, 6'h1c, 8'h80);
    trial(5'h08, 8'h80, 6'h1c, 8'h80);
    trial(5'h08, 8'h00, 6'h0c, 8'h00);
    trial(5'h0f, 8'h00, 6'h0c, 8'h00);
    repeat (40)
    begin
      lfsr_q = lfsr(lfsr_q);
      r = lfsr_q;
      lfsr_q = lfsr(lfsr_q);
      trial(rcs_src_t'(r[4:0] & r[9:5]), r[15:8] & r[7:0],
            {lfsr_q[13] ? RCS_MODE_DEEP : (lfsr_q[12] ? RCS_MODE_SHALLOW : RCS_MODE_RUN),
             lfsr_q[11:8]}, lfsr_q[7:0]);
    end
    trial(5'h02, 8'h00, 6'h0c, 8'h00);
    @(negedge core_clk);
    check(irq, 1'b0);
    wr(RCS_OFF_IRQ_MASK, 32'h1);
    @(negedge core_clk);
    check(irq, 1'b1);
    wr(RCS_OFF_IRQ_STAT, 32'h1);
    @(negedge core_clk);
    check(irq, 1'b0);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    chk_reg(RCS_OFF_CAUSE, 32'h82);
    end_of_test();
  end
endmodule
